// file: rtl/modulo_bitrev_address_gen.v
// Data-space effective-address generator with modulo and bit-reversed modes
//
// Behaviour
// R1: Modulo correction may apply to any working register chosen as pointer.
// R2: Wrap on address above end (incrementing) or below start (decrementing).
// R3: Corrected address written back to pointer only for pre/post modify modes.
// R4: Register-plus-offset gets corrected address but pointer stays unchanged.
// R5: Bit reversal only in the X write generator, for writes only.
// R6: Only the modifier is bit reversed; pointer and result keep normal order.
// R7: Bit reversal needs select not 15, enable set, pre/post increment indirect.
// R8: Software aligns a 2^N byte bit-reversed buffer to N zero low bits.
// R9: The bit-reverse modifier is a 15-bit field, typically half the buffer.
// R10: Word data assumed; modifier scaled to bytes, address bit 0 forced clear.
// R11: Other modes and byte writes get normal addresses even when enabled.
// R12: Bit-reversed next address is pointer plus modifier; mode increment ignored.
// R13: With both enabled, X writes use bit reversal without modulo; reads keep it.
// R14: Software avoids indirect read via bit-reversed pointer right after control write.
// R15: Bit-reversed add propagates carries from modifier MSB toward the LSB.
`timescale 1ns/1ps
`include "addr_gen_defines.vh"
module modulo_bitrev_address_gen #(
  parameter AW = 16
) (
  input  wire                   sys_clk,
  input  wire                   arst_n,
  input  wire [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [`AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  input  wire                   req_valid,
  input  wire                   req_xspace,
  input  wire                   req_write,
  input  wire                   req_byte,
  input  wire [2:0]             req_mode,
  input  wire [3:0]             req_wreg,
  input  wire [AW-1:0]          req_pointer,
  input  wire [AW-1:0]          req_offset,
  output reg                    ea_valid,
  output reg  [AW-1:0]          ea_addr,
  output reg                    ea_write,
  output reg                    ea_bitrev,
  output reg                    wb_valid,
  output reg  [3:0]             wb_reg,
  output reg  [AW-1:0]          wb_value
);

  // Register file
  reg  [15:0]            bit_reverse_control;
  reg  [15:0]            modulo_control_reg;
  reg  [AW-1:0]          modulo_start;
  reg  [AW-1:0]          modulo_end;
  reg  [AW-1:0]          last_write_ea;
  reg  [AW-1:0]          last_read_ea;
  reg  [15:0]            bitrev_count;

  // Write channel holding stages; address and data may come in either order
  reg                    aw_held;
  reg  [`AXI_ADDR_W-1:0] aw_addr;
  reg                    w_held;
  reg  [31:0]            w_data;
  reg  [3:0]             w_strb;

  wire                   bitrev_enable;
  wire [14:0]            bitrev_modifier;
  wire [3:0]             bitrev_pointer_select;
  wire                   modulo_enable;
  wire [3:0]             modulo_pointer_select;

  assign bitrev_enable         = bit_reverse_control[`BITREV_EN_BIT];
  assign bitrev_modifier       = bit_reverse_control[`BITREV_MOD_MSB:0]; // R9
  assign bitrev_pointer_select = modulo_control_reg[`BR_SEL_MSB:`BR_SEL_LSB];
  assign modulo_enable         = modulo_control_reg[`MODULO_EN_BIT];
  assign modulo_pointer_select = modulo_control_reg[`MOD_SEL_MSB:`MOD_SEL_LSB];

  // AXI4-Lite write side
  wire                   do_write;
  // Each half parks in its stage; a standing response blocks the next write
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  wire                   wr_mapped;
  assign wr_mapped = (aw_addr == `OFS_BITREV_CTRL) || (aw_addr == `OFS_MODULO_CTRL) ||
                     (aw_addr == `OFS_MODULO_START) || (aw_addr == `OFS_MODULO_END);

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held      <= 1'b0;
      aw_addr      <= {`AXI_ADDR_W{1'b0}};
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; a new setting steers the very next request
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_reverse_control <= `RST_BITREV_CTRL;
      modulo_control_reg  <= `RST_MODULO_CTRL;
      modulo_start        <= `RST_MODULO_START;
      modulo_end          <= `RST_MODULO_END;
    end else if (do_write) begin
      case (aw_addr)
        `OFS_BITREV_CTRL: begin
          bit_reverse_control <= merge16(bit_reverse_control, w_data, w_strb);
        end
        `OFS_MODULO_CTRL: begin
          modulo_control_reg <= merge16(modulo_control_reg, w_data, w_strb);
        end
        `OFS_MODULO_START: begin
          modulo_start <= merge16(modulo_start, w_data, w_strb);
        end
        `OFS_MODULO_END: begin
          modulo_end <= merge16(modulo_end, w_data, w_strb);
        end
        // Unmapped offsets leave every register alone
        default: begin
          modulo_start <= modulo_start;
        end
      endcase
    end
  end

  // AXI4-Lite read side
  // One read in flight; a standing answer refuses the next address
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_RESP_OKAY;
      case (s_axi_araddr)
        `OFS_BITREV_CTRL:  s_axi_rdata <= {16'h0000, bit_reverse_control};
        `OFS_MODULO_CTRL:  s_axi_rdata <= {16'h0000, modulo_control_reg};
        `OFS_MODULO_START: s_axi_rdata <= {16'h0000, modulo_start};
        `OFS_MODULO_END:   s_axi_rdata <= {16'h0000, modulo_end};
        `OFS_LAST_EA:      s_axi_rdata <= {last_write_ea, last_read_ea};
        `OFS_BITREV_COUNT: s_axi_rdata <= {16'h0000, bitrev_count};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AXI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Magnitude test, so a step that overshoots a boundary still wraps
  function [AW-1:0] modulo_fix;
    input [AW-1:0] addr;
    input          decrementing;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    reg   [AW-1:0] span;
    begin
      span = hi - lo + {{(AW-1){1'b0}}, 1'b1};
      if (!decrementing && (addr > hi)) begin
        modulo_fix = addr - span; // R2
      end else if (decrementing && (addr < lo)) begin
        modulo_fix = addr + span; // R2
      end else begin
        modulo_fix = addr;
      end
    end
  endfunction

  // Mode decode
  wire           mode_pre;
  wire           mode_post;
  wire           mode_inc;
  wire           mode_offset;
  wire [AW-1:0]  step;
  wire [AW-1:0]  stepped;
  wire [AW-1:0]  offset_sum;

  assign mode_pre    = (req_mode == `MODE_PRE_INC) || (req_mode == `MODE_PRE_DEC);
  assign mode_post   = (req_mode == `MODE_POST_INC) || (req_mode == `MODE_POST_DEC);
  assign mode_inc    = (req_mode == `MODE_PRE_INC) || (req_mode == `MODE_POST_INC);
  assign mode_offset = (req_mode == `MODE_REG_OFFSET);
  // Byte accesses step by one, word accesses by two
  assign step        = req_byte ? `STEP_BYTE : `STEP_WORD;
  assign stepped     = mode_inc ? (req_pointer + step) : (req_pointer - step);
  assign offset_sum  = req_pointer + req_offset;

  // Bit-reversed qualification
  wire           x_write_address_unit;
  wire           bitrev_active;
  wire [AW-1:0]  bitrev_sum;
  wire [AW-1:0]  bitrev_next;

  assign x_write_address_unit = req_xspace & req_write; // R5
  assign bitrev_active = x_write_address_unit & ~req_byte & bitrev_enable &
                         (bitrev_pointer_select != `SP_SELECT) &
                         (req_wreg == bitrev_pointer_select) &
                         mode_inc; // R7 R11

  // Modifier scaled to bytes; pointer enters in normal order
  bitrev_adder #(
    .WIDTH (AW)
  ) u_bitrev_adder (
    .base     (req_pointer),
    .modifier ({bitrev_modifier, 1'b0}),
    .sum      (bitrev_sum)
  ); // R6 R10

  // Bit 0 cleared after the add, so an odd pointer never reaches the address
  assign bitrev_next = bitrev_sum & `WORD_ALIGN_MASK; // R10 R12

  // Bit reversal armed: enable set and a pointer other than the stack
  wire           bitrev_armed;
  assign bitrev_armed = bitrev_enable & (bitrev_pointer_select != `SP_SELECT); // R7

  // Modulo qualification; the write generator gives way to bit reversal
  wire           modulo_hit;
  assign modulo_hit = modulo_enable & (req_wreg == modulo_pointer_select) &
                      ~(x_write_address_unit & bitrev_armed); // R1 R13

  // Offset mode wraps in the direction given by the offset's sign
  wire [AW-1:0]  stepped_fixed;
  wire [AW-1:0]  offset_fixed;
  assign stepped_fixed = modulo_hit ? modulo_fix(stepped, ~mode_inc, modulo_start, modulo_end)
                                    : stepped;
  assign offset_fixed  = modulo_hit ? modulo_fix(offset_sum, req_offset[AW-1],
                                                  modulo_start, modulo_end)
                                    : offset_sum; // R4

  // Effective address and write-back selection
  reg  [AW-1:0]  next_ea;
  reg            next_wb_valid;
  reg  [AW-1:0]  next_wb_value;

  always @* begin
    next_ea       = req_pointer;
    next_wb_valid = 1'b0;
    next_wb_value = req_pointer;
    if (bitrev_active) begin
      next_ea       = mode_pre ? bitrev_next : (req_pointer & `WORD_ALIGN_MASK); // R10
      next_wb_valid = 1'b1;
      next_wb_value = bitrev_next; // R12
    end else if (mode_pre) begin
      next_ea       = stepped_fixed;
      next_wb_valid = 1'b1;
      next_wb_value = stepped_fixed; // R3
    end else if (mode_post) begin
      next_ea       = req_pointer;
      next_wb_valid = 1'b1;
      next_wb_value = stepped_fixed; // R3
    end else if (mode_offset) begin
      next_ea       = offset_fixed;
      next_wb_valid = 1'b0; // R4
    end
  end

  // Results stand one cycle after the request
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_valid  <= 1'b0;
      ea_addr   <= {AW{1'b0}};
      ea_write  <= 1'b0;
      ea_bitrev <= 1'b0;
      wb_valid  <= 1'b0;
      wb_reg    <= 4'h0;
      wb_value  <= {AW{1'b0}};
    end else begin
      ea_valid <= req_valid;
      wb_valid <= req_valid & next_wb_valid;
      if (req_valid) begin
        ea_addr   <= next_ea;
        ea_write  <= req_write;
        ea_bitrev <= bitrev_active;
        wb_reg    <= req_wreg;
        wb_value  <= next_wb_value;
      end
    end
  end

  // Status seen by software
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_write_ea <= {AW{1'b0}};
      last_read_ea  <= {AW{1'b0}};
      bitrev_count  <= 16'h0000;
    end else if (req_valid) begin
      // Kept per direction so software can tell reads from writes
      if (req_write) begin
        last_write_ea <= next_ea;
      end else begin
        last_read_ea <= next_ea;
      end
      // Wraps silently; software reads differences
      if (bitrev_active) begin
        bitrev_count <= bitrev_count + 16'h0001;
      end
    end
  end

endmodule

// file: rtl/addr_gen_defines.vh
// Offsets, fields, reset values and encodings of the address generator
`ifndef ADDR_GEN_DEFINES_VH
`define ADDR_GEN_DEFINES_VH

`define AXI_ADDR_W          8
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`define OFS_BITREV_CTRL     8'h00
`define OFS_MODULO_CTRL     8'h04
`define OFS_MODULO_START    8'h08
`define OFS_MODULO_END      8'h0c
`define OFS_LAST_EA         8'h10
`define OFS_BITREV_COUNT    8'h14

`define BITREV_EN_BIT       15
`define BITREV_MOD_MSB      14
`define MODULO_EN_BIT       15
`define BR_SEL_MSB          11
`define BR_SEL_LSB          8
`define MOD_SEL_MSB         3
`define MOD_SEL_LSB         0

`define RST_BITREV_CTRL     16'h0000
`define RST_MODULO_CTRL     16'h0f00
`define RST_MODULO_START    16'h0000
`define RST_MODULO_END      16'hffff

`define SP_SELECT           4'hf

`define MODE_INDIRECT       3'h0
`define MODE_POST_INC       3'h1
`define MODE_POST_DEC       3'h2
`define MODE_PRE_INC        3'h3
`define MODE_PRE_DEC        3'h4
`define MODE_REG_OFFSET     3'h5

`define STEP_BYTE           16'h0001
`define STEP_WORD           16'h0002
`define WORD_ALIGN_MASK     16'hfffe

`endif

// file: rtl/bitrev_adder.v
// Adder whose carries run from the most significant bit toward bit 0
`timescale 1ns/1ps
module bitrev_adder #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] base,
  input  wire [WIDTH-1:0] modifier,
  output wire [WIDTH-1:0] sum
);
  wire [WIDTH-1:0] base_rev;
  wire [WIDTH-1:0] mod_rev;
  wire [WIDTH-1:0] sum_rev;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_rev
      assign base_rev[i] = base[WIDTH-1-i];
      assign mod_rev[i]  = modifier[WIDTH-1-i];
      assign sum[i]      = sum_rev[WIDTH-1-i];
    end
  endgenerate

  // Carry out of the reversed add falls off, keeping the walk inside the buffer
  assign sum_rev = base_rev + mod_rev; // R15
endmodule

// file: dv/addr_gen_checker_assertions.sv
// Port-level assertions for the address generator
`timescale 1ns/1ps
`include "addr_gen_defines.vh"
module addr_gen_checker #(
  parameter AW = 16
) (
  input wire          sys_clk,
  input wire          arst_n,
  input wire          s_axi_arvalid,
  input wire          s_axi_arready,
  input wire          s_axi_rvalid,
  input wire          req_valid,
  input wire          req_xspace,
  input wire          req_write,
  input wire          req_byte,
  input wire [2:0]    req_mode,
  input wire [3:0]    req_wreg,
  input wire [AW-1:0] req_pointer,
  input wire          ea_valid,
  input wire [AW-1:0] ea_addr,
  input wire          ea_write,
  input wire          ea_bitrev,
  input wire          wb_valid,
  input wire [3:0]    wb_reg,
  input wire [AW-1:0] wb_value
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ea_answer_a: assert property (req_valid |=> ea_valid && ea_write == $past(req_write))
    else $error("address answer missing");
  ea_idle_a: assert property (!req_valid |=> !ea_valid && !wb_valid)
    else $error("answer without request");
  wb_target_a: assert property (req_valid && req_mode != `MODE_INDIRECT &&
    req_mode != `MODE_REG_OFFSET |=> wb_valid && wb_reg == $past(req_wreg))
    else $error("pointer write-back wrong");
  offset_keep_a: assert property (req_valid && (req_mode == `MODE_REG_OFFSET ||
    req_mode == `MODE_INDIRECT) |=> !wb_valid)
    else $error("pointer changed without modify mode");
  br_gate_a: assert property (req_valid && !(req_xspace && req_write && !req_byte &&
    (req_mode == `MODE_POST_INC || req_mode == `MODE_PRE_INC)) |=> !ea_bitrev)
    else $error("bit reversal outside word write increment");
  br_even_a: assert property (ea_valid && ea_bitrev |-> !ea_addr[0] && !wb_value[0])
    else $error("bit-reversed address odd");
  post_ea_a: assert property (req_valid && (req_mode == `MODE_POST_INC ||
    req_mode == `MODE_POST_DEC) && !req_pointer[0] |=> ea_addr == $past(req_pointer))
    else $error("post mode address not pointer");
  br_wb_a: assert property (ea_valid && ea_bitrev |-> wb_valid && ea_write)
    else $error("bit-reversed step not written back");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind modulo_bitrev_address_gen addr_gen_checker #(.AW(AW)) u_chk (.*);

// file: dv/pipe_model.sv
// Pipeline-side model that issues address requests
`timescale 1ns/1ps
module pipe_model #(
  parameter AW = 16
) (
  input  wire          sys_clk,
  output reg           req_valid,
  output reg           req_xspace,
  output reg           req_write,
  output reg           req_byte,
  output reg  [2:0]    req_mode,
  output reg  [3:0]    req_wreg,
  output reg  [AW-1:0] req_pointer,
  output reg  [AW-1:0] req_offset
);
  initial begin
    {req_valid, req_xspace, req_write, req_byte, req_mode, req_wreg} = 11'h000;
    {req_pointer, req_offset} = 0;
  end
  // Pointer, offset and mode scrambled after the taking edge, so stale values cannot pass
  task issue(input [2:0] m, input x, w, b, input [3:0] r, input [AW-1:0] p, o);
    @(posedge sys_clk);
    {req_valid, req_xspace, req_write, req_byte, req_mode, req_wreg} <= {1'b1, x, w, b, m, r};
    {req_pointer, req_offset} <= {p, o};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    {req_pointer, req_offset, req_mode} <= ~{p, o, m};
  endtask
endmodule

// file: dv/test_modulo_bitrev_address_gen.sv
// Self-checking bench for the address generator
`timescale 1ns/1ps
`include "addr_gen_defines.vh"
module test_modulo_bitrev_address_gen;
  reg         sys_clk, arst_n;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata;
  reg  [3:0]  s_axi_wstrb;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        req_valid, req_xspace, req_write, req_byte;
  wire        ea_valid, ea_write, ea_bitrev, wb_valid;
  wire [2:0]  req_mode;
  wire [3:0]  req_wreg, wb_reg;
  wire [15:0] req_pointer, req_offset, ea_addr, wb_value;
  integer     err_total, compares, i, k, nbr;
  reg  [15:0] lf, brc, mc, p, o, e_ea, e_wv, lw, lr;
  reg         e_wbv, e_br, b;
  reg  [31:0] cfg [0:3];

  modulo_bitrev_address_gen #(.AW(16)) u_dut (.*);
  pipe_model #(.AW(16)) pm (.*);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task chk(input [31:0] s, input [31:0] e);
    compares = compares + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  function [15:0] rev(input [15:0] v);
    integer j;
    for (j = 0; j < 16; j = j + 1) rev[j] = v[15-j];
  endfunction

  function [15:0] lfsr_next(input [15:0] v);
    lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  // Reference address arithmetic, buffer fixed at 0x1000..0x101f
  task model(input [2:0] m, input x, w, b, input [3:0] r, input [15:0] p, o);
    reg [15:0] a;
    reg        dec, mo;
    e_br = x && w && !b && brc[15] && mc[11:8] != 4'hf && r == mc[11:8] && (m == 1 || m == 3);
    mo = mc[15] && r == mc[3:0] && !(x && w && brc[15] && mc[11:8] != 4'hf);
    dec = m == 2 || m == 4 || (m == 5 && o[15]);
    a = (m == 5) ? p + o : dec ? p - (b ? `STEP_BYTE : `STEP_WORD) : p + (b ? `STEP_BYTE : `STEP_WORD);
    if (mo && !dec && a > 16'h101f) a = a - 16'h0020;
    if (mo && dec && a < 16'h1000) a = a + 16'h0020;
    e_ea = (m <= 2) ? p : a;
    e_wbv = m != 0 && m != 5;
    e_wv = a;
    if (e_br) begin
      // Carries run toward bit 0 by reversing, adding and reversing back
      a = rev(rev(p) + rev({brc[14:0], 1'b0})) & `WORD_ALIGN_MASK;
      e_ea = (m == 3) ? a : p & `WORD_ALIGN_MASK;
      e_wv = a;
    end
  endtask

  task req(input [2:0] m, input x, w, b, input [3:0] r, input [15:0] p, o);
    model(m, x, w, b, r, p, o);
    pm.issue(m, x, w, b, r, p, o);
    #1;
    chk(ea_valid, 1'b1);
    chk(ea_addr, e_ea);
    chk(ea_bitrev, e_br);
    chk(ea_write, w);
    chk(wb_valid, e_wbv);
    if (e_wbv) chk(wb_value, e_wv);
    if (e_wbv) chk(wb_reg, r);
    if (w) lw = e_ea;
    else lr = e_ea;
    if (e_br) nbr = nbr + 1;
  endtask

  task conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge sys_clk);
    err_total = err_total + 1;
    conclude;
  end

  initial begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
    err_total = 0;
    compares = 0;
    nbr = 0;
    {lw, lr} = 32'h0;
    lf = 16'h0034;
    // Overlapping modulo and bit-reverse pointers exercise the priority case
    cfg[0] = {16'h8f03, 16'h8008};
    cfg[1] = {16'h8303, 16'h8008};
    cfg[2] = {16'h8a0a, 16'h8004};
    cfg[3] = {16'h0505, 16'h8010};
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(8'h00, 32'h0, `AXI_RESP_OKAY);
    rd(8'h04, 32'h0f00, `AXI_RESP_OKAY);
    rd(8'h0c, 32'hffff, `AXI_RESP_OKAY);
    rd(8'h20, 32'h0, `AXI_RESP_SLVERR);
    wr(8'h10, 32'h1, `AXI_RESP_SLVERR);
    wr(8'h08, 32'h1000, `AXI_RESP_OKAY);
    wr(8'h0c, 32'h101f, `AXI_RESP_OKAY);
    rd(8'h08, 32'h1000, `AXI_RESP_OKAY);
    for (k = 0; k < 4; k = k + 1) begin
      {mc, brc} = cfg[k];
      wr(8'h04, mc, `AXI_RESP_OKAY);
      wr(8'h00, brc, `AXI_RESP_OKAY);
      // Read-back sits between the control write and any pointer read
      rd(8'h00, brc, `AXI_RESP_OKAY);
      rd(8'h04, mc, `AXI_RESP_OKAY);
      for (i = 0; i < 60; i = i + 1) begin
        lf = lfsr_next(lf);
        b = lf[7];
        p = 16'h1000 + {lf[4:1], b & lf[0]};
        o = {{11{lf[10]}}, lf[15:11]};
        req(lf[11:9] % 3'd6, lf[12], lf[13], b, lf[14] ? mc[3:0] : lf[3:0], p, o);
      end
      rd(8'h10, {lw, lr}, `AXI_RESP_OKAY);
      rd(8'h14, nbr, `AXI_RESP_OKAY);
    end
    // Mid-run reset brings back the reset values and clears the status
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(8'h00, 32'h0, `AXI_RESP_OKAY);
    rd(8'h04, 32'h0f00, `AXI_RESP_OKAY);
    rd(8'h10, 32'h0, `AXI_RESP_OKAY);
    rd(8'h14, 32'h0, `AXI_RESP_OKAY);
    {mc, brc} = {16'h0f00, 16'h0000};
    req(3'd3, 1'b1, 1'b1, 1'b0, 4'h2, 16'h1000, 16'h0000);
    conclude;
  end
endmodule
